// *** pkg/dlp_defs.vh ***
`ifndef DLP_DEFS_VH
`define DLP_DEFS_VH
`define DLP_CLK_NS 40
`define DLP_READY_NS 10000
`define DLP_READY_CYC (`DLP_READY_NS / `DLP_CLK_NS)
`define DLP_ZC_WIN_MS 50
`define DLP_ZC_WIN_CYC (`DLP_ZC_WIN_MS * 1000000 / `DLP_CLK_NS)
`define DLP_DEV_CODE 4'h5
`define DLP_CODE_HI 7
`define DLP_CODE_LO 4
`define DLP_SEL_HI 3
`define DLP_SEL_LO 1
`define DLP_RW_BIT 0
`define DLP_CMD_POT0 8'ha9
`define DLP_CMD_POT1 8'haa
`define DLP_CMD_BOTH 8'haf
`define DLP_CMD_ZC_ON 8'hbd
`define DLP_CMD_ZC_OFF 8'hbe
`define DLP_POS_RESET 8'h3f
`define DLP_MUTE_BIT 6
`define DLP_TAP_MUTE 7'h40
`define DLP_IDX_ADDR 3'h0
`define DLP_IDX_CMD 3'h1
`define DLP_IDX_D0 3'h2
`define DLP_IDX_D1 3'h3
`endif

// *** core/dlp_wiper_apply.v ***
`timescale 1ns/1ns
`default_nettype none
`include "dlp_defs.vh"
module dlp_wiper_apply #(
	parameter WIN_CYC = `DLP_ZC_WIN_CYC,
	parameter CNT_W = 21
) (
	input wire sys_clk,
	input wire rst_b,
	input wire load,
	input wire [7:0] load_val,
	input wire zc_en,
	input wire zero_cross_in,
	output reg [6:0] wiper_tap_r
);
	// Wide copy first so the cut to the counter width is deliberate
	localparam [31:0] WIN_LAST_W = WIN_CYC - 1;
	localparam [CNT_W-1:0] WIN_LAST = WIN_LAST_W[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	reg zc_m_r;
	reg zc_s_r;
	reg pend_r;
	reg [7:0] pend_val_r;
	reg [CNT_W-1:0] win_cnt_r;

	function [6:0] tap_of;
		input [7:0] v;
		begin
			// Bit 7 ignored; mute bit overrides the step bits
			if (v[`DLP_MUTE_BIT])
				tap_of = `DLP_TAP_MUTE;
			else
				tap_of = {1'b0, v[5:0]};
		end
	endfunction

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			zc_m_r <= 1'b0;
			zc_s_r <= 1'b0;
			pend_r <= 1'b0;
			pend_val_r <= `DLP_POS_RESET;
			win_cnt_r <= {CNT_W{1'b0}};
			wiper_tap_r <= `DLP_TAP_MUTE - 7'h01;
		end else begin
			zc_m_r <= zero_cross_in;
			zc_s_r <= zc_m_r;
			if (load) begin
				pend_val_r <= load_val;
				win_cnt_r <= {CNT_W{1'b0}};
				if (zc_en) begin
					pend_r <= 1'b1;
				end else begin
					pend_r <= 1'b0;
					wiper_tap_r <= tap_of(load_val);
				end
			end else if (pend_r && (zc_s_r || !zc_en || win_cnt_r == WIN_LAST)) begin
				pend_r <= 1'b0;
				wiper_tap_r <= tap_of(pend_val_r);
			end else if (pend_r) begin
				win_cnt_r <= win_cnt_r + CNT_ONE;
			end
		end
	end
endmodule
`default_nettype wire

// *** core/dlp_wiper_ctrl.v ***
// How it works
// - Two 8-bit wiper registers, 65 taps each
// - Bits 0-5 pick tap, 1 dB steps
// - Bit 6 set forces mute tap
// - Bit 7 ignored for tap selection
// - Tap 64 is low terminal, mute
// - Zero value selects high terminal tap
// - Serial port answers within 10 us
// - Both wipers reset to position 63
// - Three address pins give bus address
// - Write wipers singly or together, read back
// - Zero-crossing mode switched by serial commands
// - Zero-crossing on: update at crossing, per pot
// - Window starts at write acknowledge
// - No crossing in 50 ms: update anyway
// - Zero-crossing off: update at acknowledge
// - Zero-crossing enabled after power-up
// - Device is slave only, master clocks
// - Data line open drain, clock input
// - Data change during clock high is control
// - Address byte code and select must match, direction bit taken as given
// - All bytes most significant bit first
// - Read returns pot0 then pot1 bytes
`timescale 1ns/1ns
`default_nettype none
`include "dlp_defs.vh"
module dlp_wiper_ctrl #(
	parameter ZC_WIN_CYC = `DLP_ZC_WIN_CYC,
	parameter ZC_CNT_W = 21
) (
	input wire sys_clk,
	input wire rst_b,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_r,
	output reg sda_oe_b_r,
	input wire addr_sel_bit0,
	input wire addr_sel_bit1,
	input wire addr_sel_bit2,
	input wire pot0_zero_cross,
	input wire pot1_zero_cross,
	output wire [6:0] pot0_wiper_tap,
	output wire [6:0] pot1_wiper_tap,
	output reg zc_enabled_r,
	output reg bus_ready_r
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_RX = 5'h02;
	localparam [4:0] ST_ACK = 5'h04;
	localparam [4:0] ST_TX = 5'h08;
	localparam [4:0] ST_RACK = 5'h10;
	localparam [31:0] READY_LAST_W = `DLP_READY_CYC - 1;
	localparam [8:0] READY_LAST = READY_LAST_W[8:0];
	localparam [3:0] BITS_PER_BYTE = 4'h8;

	reg scl_m_r;
	reg scl_s_r;
	reg scl_q_r;
	reg sda_m_r;
	reg sda_s_r;
	reg sda_q_r;
	reg [2:0] addr_m_r;
	reg [2:0] addr_s_r;
	reg [8:0] ready_cnt_r;
	reg [4:0] state_r;
	reg [3:0] bit_cnt_r;
	reg [2:0] byte_idx_r;
	reg [7:0] shift_r;
	reg [7:0] tx_r;
	reg [7:0] cmd_r;
	reg rw_r;
	reg rd_sel_r;
	reg [7:0] pos0_r;
	reg [7:0] pos1_r;
	reg [1:0] load_r;
	reg [7:0] load_val_r;
	wire [13:0] tap_bus;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire [1:0] zc_in;

	// Which wipers a data byte at this position writes
	function [1:0] wr_mask;
		input [7:0] cmd;
		input [2:0] idx;
		begin
			wr_mask = 2'b00;
			case (cmd)
			`DLP_CMD_POT0: begin
				if (idx == `DLP_IDX_D0)
					wr_mask = 2'b01;
				else if (idx == `DLP_IDX_D1)
					wr_mask = 2'b10;
			end
			`DLP_CMD_POT1: begin
				if (idx == `DLP_IDX_D0)
					wr_mask = 2'b10;
			end
			`DLP_CMD_BOTH: begin
				if (idx == `DLP_IDX_D0)
					wr_mask = 2'b11;
			end
			default: begin
				wr_mask = 2'b00;
			end
			endcase
		end
	endfunction

	function cmd_ok;
		input [7:0] cmd;
		begin
			cmd_ok = (cmd == `DLP_CMD_POT0) || (cmd == `DLP_CMD_POT1) || (cmd == `DLP_CMD_BOTH) ||
				(cmd == `DLP_CMD_ZC_ON) || (cmd == `DLP_CMD_ZC_OFF);
		end
	endfunction

	assign scl_rise = scl_s_r & ~scl_q_r;
	assign scl_fall = ~scl_s_r & scl_q_r;
	// Edge on data while clock stays high is a bus condition
	assign start_det = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
	assign stop_det = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
	assign zc_in = {pot1_zero_cross, pot0_zero_cross};
	assign pot0_wiper_tap = tap_bus[6:0];
	assign pot1_wiper_tap = tap_bus[13:7];

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_pot
			dlp_wiper_apply #(
				.WIN_CYC(ZC_WIN_CYC),
				.CNT_W(ZC_CNT_W)
			) u_apply (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.load(load_r[g]),
				.load_val(load_val_r),
				.zc_en(zc_enabled_r),
				.zero_cross_in(zc_in[g]),
				.wiper_tap_r(tap_bus[g*7 +: 7])
			);
		end
	endgenerate

	// Master owns the clock; pins pass two flops before use
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_q_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_q_r <= 1'b1;
			addr_m_r <= 3'h0;
			addr_s_r <= 3'h0;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_q_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_q_r <= sda_s_r;
			addr_m_r <= {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
			addr_s_r <= addr_m_r;
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ready_cnt_r <= 9'h000;
			bus_ready_r <= 1'b0;
		end else if (ready_cnt_r != READY_LAST) begin
			ready_cnt_r <= ready_cnt_r + 9'h001;
		end else begin
			bus_ready_r <= 1'b1;
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			sda_out_r <= 1'b0;
			sda_oe_b_r <= 1'b1;
			bit_cnt_r <= 4'h0;
			byte_idx_r <= `DLP_IDX_ADDR;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			cmd_r <= 8'h00;
			rw_r <= 1'b0;
			rd_sel_r <= 1'b0;
			pos0_r <= `DLP_POS_RESET;
			pos1_r <= `DLP_POS_RESET;
			load_r <= 2'b00;
			load_val_r <= `DLP_POS_RESET;
			zc_enabled_r <= 1'b1;
		end else begin
			load_r <= 2'b00;
			sda_out_r <= 1'b0;
			// Bus is ignored until the power-up hold-off ends
			if (!bus_ready_r) begin
				state_r <= ST_IDLE;
				sda_oe_b_r <= 1'b1;
			end else if (stop_det) begin
				state_r <= ST_IDLE;
				sda_oe_b_r <= 1'b1;
			end else if (start_det) begin
				state_r <= ST_RX;
				sda_oe_b_r <= 1'b1;
				bit_cnt_r <= 4'h0;
				byte_idx_r <= `DLP_IDX_ADDR;
			end else begin
				case (state_r)
				ST_RX: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_s_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
						state_r <= ST_IDLE;
						if (byte_idx_r == `DLP_IDX_ADDR) begin
							if (shift_r[`DLP_CODE_HI:`DLP_CODE_LO] == `DLP_DEV_CODE &&
								shift_r[`DLP_SEL_HI:`DLP_SEL_LO] == addr_s_r) begin
								rw_r <= shift_r[`DLP_RW_BIT];
								state_r <= ST_ACK;
								sda_oe_b_r <= 1'b0;
							end
						end else if (byte_idx_r == `DLP_IDX_CMD) begin
							cmd_r <= shift_r;
							if (cmd_ok(shift_r)) begin
								state_r <= ST_ACK;
								sda_oe_b_r <= 1'b0;
							end
						end else if (wr_mask(cmd_r, byte_idx_r) != 2'b00) begin
							load_val_r <= shift_r;
							state_r <= ST_ACK;
							sda_oe_b_r <= 1'b0;
						end
					end
				end
				ST_ACK: begin
					// Acknowledge clock ends here; actions take effect now
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (byte_idx_r == `DLP_IDX_ADDR && rw_r) begin
							state_r <= ST_TX;
							tx_r <= pos0_r;
							sda_oe_b_r <= pos0_r[7];
							rd_sel_r <= 1'b0;
						end else begin
							state_r <= ST_RX;
							sda_oe_b_r <= 1'b1;
							if (byte_idx_r != `DLP_IDX_D1)
								byte_idx_r <= byte_idx_r + 3'h1;
							if (byte_idx_r == `DLP_IDX_CMD) begin
								if (cmd_r == `DLP_CMD_ZC_ON)
									zc_enabled_r <= 1'b1;
								else if (cmd_r == `DLP_CMD_ZC_OFF)
									zc_enabled_r <= 1'b0;
							end else begin
								load_r <= wr_mask(cmd_r, byte_idx_r);
								if (wr_mask(cmd_r, byte_idx_r) == 2'b01 || wr_mask(cmd_r, byte_idx_r) == 2'b11)
									pos0_r <= load_val_r;
								if (wr_mask(cmd_r, byte_idx_r) == 2'b10 || wr_mask(cmd_r, byte_idx_r) == 2'b11)
									pos1_r <= load_val_r;
							end
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_r == BITS_PER_BYTE) begin
							state_r <= ST_RACK;
							sda_oe_b_r <= 1'b1;
						end else begin
							tx_r <= {tx_r[6:0], 1'b0};
							sda_oe_b_r <= tx_r[6];
						end
					end
				end
				ST_RACK: begin
					// Master not acknowledging ends the read; line stays released
					if (scl_rise) begin
						if (sda_s_r)
							state_r <= ST_IDLE;
						else
							rd_sel_r <= ~rd_sel_r;
					end else if (scl_fall) begin
						state_r <= ST_TX;
						bit_cnt_r <= 4'h0;
						tx_r <= rd_sel_r ? pos1_r : pos0_r;
						sda_oe_b_r <= rd_sel_r ? pos1_r[7] : pos0_r[7];
					end
				end
				default: begin
					state_r <= ST_IDLE;
					sda_oe_b_r <= 1'b1;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** core/dlp_wiper_ctrl_unused_guard.v ***
`timescale 1ns/1ns

// *** testbench/dlp_ctrl_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module dlp_ctrl_props #(
	parameter ZC_WIN_CYC = 1250000,
	parameter ZC_CNT_W = 21
) (
	input wire sys_clk,
	input wire rst_b,
	input wire scl_in,
	input wire sda_out_r,
	input wire sda_oe_b_r,
	input wire [6:0] pot0_wiper_tap,
	input wire [6:0] pot1_wiper_tap,
	input wire zc_enabled_r,
	input wire bus_ready_r
);
	logic [8:0] rdy_cnt_r;
	logic [8:0] rdy_cnt_nxt;
	// Saturates so a dead port cannot wrap back into range
	always_comb rdy_cnt_nxt = (bus_ready_r || rdy_cnt_r == 9'h1ff) ? rdy_cnt_r : rdy_cnt_r + 9'h001;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			rdy_cnt_r <= 9'h000;
		else
			rdy_cnt_r <= rdy_cnt_nxt;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_ready_time; rdy_cnt_r <= 9'h0fc; endproperty
	a_ready_time: assert property (p_ready_time) else $error("Serial port late");
	property p_ready_hold; bus_ready_r |=> bus_ready_r; endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("Serial port dropped");
	property p_quiet_early; !bus_ready_r |-> sda_oe_b_r; endproperty
	a_quiet_early: assert property (p_quiet_early) else $error("Data driven before ready");
	property p_drain_zero; sda_out_r == 1'b0; endproperty
	a_drain_zero: assert property (p_drain_zero) else $error("Data line driven high");
	property p_tap0_range; pot0_wiper_tap <= 7'h40; endproperty
	a_tap0_range: assert property (p_tap0_range) else $error("Tap 0 out of range");
	property p_tap1_range; pot1_wiper_tap <= 7'h40; endproperty
	a_tap1_range: assert property (p_tap1_range) else $error("Tap 1 out of range");
	property p_reset_vals;
		$rose(rst_b) |-> pot0_wiper_tap == 7'h3f && pot1_wiper_tap == 7'h3f && zc_enabled_r && !bus_ready_r;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("Bad power-up state");
	property p_sda_low_clk; $changed(sda_oe_b_r) |-> !$past(scl_in); endproperty
	a_sda_low_clk: assert property (p_sda_low_clk) else $error("Data moved with clock high");
endmodule
bind dlp_wiper_ctrl dlp_ctrl_props #(.ZC_WIN_CYC(ZC_WIN_CYC), .ZC_CNT_W(ZC_CNT_W)) u_props (.sys_clk(sys_clk),
	.rst_b(rst_b), .scl_in(scl_in), .sda_out_r(sda_out_r), .sda_oe_b_r(sda_oe_b_r), .pot0_wiper_tap(pot0_wiper_tap),
	.pot1_wiper_tap(pot1_wiper_tap), .zc_enabled_r(zc_enabled_r), .bus_ready_r(bus_ready_r));
`default_nettype wire

// *** testbench/dlp_mst_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dlp_mst_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic oe_b
);
	// Bus idles with both lines high
	initial begin
		scl = 1'b1;
		oe_b = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bitx(input logic b, output logic r);
		scl <= 1'b0;
		tick(2);
		oe_b <= b;
		tick(2);
		scl <= 1'b1;
		tick(4);
		r = sda;
	endtask
	task automatic start();
		oe_b <= 1'b0;
		tick(4);
	endtask
	task automatic stop();
		scl <= 1'b0;
		tick(2);
		oe_b <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		oe_b <= 1'b1;
		tick(4);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(!mack, r);
	endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dlp_defs.vh"
module testbench;
	localparam int WIN = 2000;
	logic sys_clk, rst_b, z0, z1;
	logic [2:0] sel;
	logic [7:0] cw, wv0, wv1;
	logic [6:0] e0, e1;
	logic [6:0] q0[$];
	logic [6:0] q1[$];
	logic [7:0] tbl[8] = '{8'h00, 8'h3f, 8'h40, 8'h80, 8'hbf, 8'h7f, 8'h06, 8'h01};
	int failures = 0, num_checks = 0, cyc = 0, seed;
	wire scl, m_oe_b, d_oe_b, d_out, zc_en, rdy;
	wire [6:0] tap0, tap1;
	wire sda = m_oe_b & d_oe_b;
	dlp_mst_model u_mst (.clk(sys_clk), .sda(sda), .scl(scl), .oe_b(m_oe_b));
	dlp_wiper_ctrl #(.ZC_WIN_CYC(WIN), .ZC_CNT_W(21)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda), .sda_out_r(d_out), .sda_oe_b_r(d_oe_b), .addr_sel_bit0(sel[0]), .addr_sel_bit1(sel[1]),
		.addr_sel_bit2(sel[2]), .pot0_zero_cross(z0), .pot1_zero_cross(z1), .pot0_wiper_tap(tap0),
		.pot1_wiper_tap(tap1), .zc_enabled_r(zc_en), .bus_ready_r(rdy));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [6:0] tapf(input logic [7:0] v);
		return v[6] ? 7'h40 : {1'b0, v[5:0]};
	endfunction
	// Only a real tap change is queued, the monitor sees edges
	task automatic note(input logic p, input logic [7:0] v);
		logic [6:0] t;
		t = tapf(v);
		if (p) begin
			wv1 = v;
			if (t !== e1) q1.push_back(t);
			e1 = t;
		end else begin
			wv0 = v;
			if (t !== e0) q0.push_back(t);
			e0 = t;
		end
	endtask
	task automatic wr(input logic [7:0] c, cmd, a, b, input int n, input logic [4:0] ex);
		logic k;
		u_mst.start();
		u_mst.wbyte(c, k);
		chk(k, ex[0]);
		u_mst.wbyte(cmd, k);
		chk(k, ex[1]);
		for (int i = 0; i < n; i++) begin
			u_mst.wbyte(i == 0 ? a : b, k);
			chk(k, ex[i + 2]);
		end
		u_mst.stop();
	endtask
	task automatic rd();
		logic k;
		logic [7:0] d;
		u_mst.start();
		u_mst.wbyte(cw | 8'h01, k);
		chk(k, 1'b1);
		u_mst.rbyte(1'b1, d);
		chk(d, wv0);
		u_mst.rbyte(1'b1, d);
		chk(d, wv1);
		u_mst.rbyte(1'b0, d);
		chk(d, wv0);
		u_mst.stop();
	endtask
	always @(tap0) if (rst_b === 1'b1) chk(tap0, q0.size() ? q0.pop_front() : 8'hff);
	always @(tap1) if (rst_b === 1'b1) chk(tap1, q1.size() ? q1.pop_front() : 8'hff);
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		logic [6:0] old;
		logic [7:0] v;
		seed = 32'h6271;
		rst_b = 1'b0;
		{z0, z1} = 2'b00;
		sel = 3'h5;
		cw = {`DLP_DEV_CODE, sel, 1'b0};
		{wv0, wv1, e0, e1} = {8'h3f, 8'h3f, 7'h3f, 7'h3f};
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		chk(tap0, 8'h3f);
		chk(tap1, 8'h3f);
		chk(zc_en, 1'b1);
		repeat (260) @(posedge sys_clk);
		chk(rdy, 1'b1);
		rd();
		wr({4'h6, sel, 1'b0}, `DLP_CMD_POT0, 8'h00, 8'h00, 1, 5'b00000);
		wr(cw ^ 8'h02, `DLP_CMD_POT0, 8'h00, 8'h00, 1, 5'b00000);
		sel <= 3'($random(seed));
		repeat (5) @(posedge sys_clk);
		cw = {`DLP_DEV_CODE, sel, 1'b0};
		wr(cw, `DLP_CMD_ZC_OFF, 8'h00, 8'h00, 0, 5'b00011);
		chk(zc_en, 1'b0);
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			note(1'b0, tbl[i]);
			note(1'b1, v);
			wr(cw, `DLP_CMD_POT0, tbl[i], v, 3, 5'b11111);
			rd();
		end
		v = 8'($random(seed));
		note(1'b1, v);
		wr(cw, `DLP_CMD_POT1, v, v, 2, 5'b00111);
		v = 8'($random(seed));
		note(1'b0, v);
		note(1'b1, v);
		wr(cw, `DLP_CMD_BOTH, v, v, 2, 5'b00111);
		wr(cw, 8'h00, v, v, 0, 5'b00001);
		rd();
		wr(cw, `DLP_CMD_ZC_ON, v, v, 0, 5'b00011);
		chk(zc_en, 1'b1);
		old = e0;
		wr(cw, `DLP_CMD_POT0, ~v, v, 1, 5'b00111);
		v = 8'($random(seed));
		note(1'b0, v);
		wr(cw, `DLP_CMD_POT0, v, v, 1, 5'b00111);
		note(1'b1, ~v);
		wr(cw, `DLP_CMD_POT1, ~v, v, 1, 5'b00111);
		repeat (50) @(posedge sys_clk);
		z1 <= 1'b1;
		repeat (10) @(posedge sys_clk);
		z1 <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk(tap0, old);
		chk(q1.size() == 0, 1'b1);
		// First write's window has run out, the restarted one has not
		repeat (WIN - 450) @(posedge sys_clk);
		chk(tap0, old);
		repeat (500) @(posedge sys_clk);
		chk(q0.size() == 0, 1'b1);
		rd();
		end_of_test();
	end
endmodule
`default_nettype wire
